// file: core/hbf_pkg.sv
// Package with the block framer constants and carrier types.
package hbf_pkg;
    // Block layout.
    localparam logic [7:0] MAX_PAYLOAD = 8'h00_FE;
    localparam logic [7:0] LEN_RESERVED = 8'h00_FF;
    localparam logic [7:0] DEFAULT_SIZE_LIMIT = 8'h00_20;
    // Node address byte fields.
    localparam int ADDR_UNUSED_HI = 7;
    localparam int ADDR_UNUSED_LO = 3;
    localparam logic [7:0] ADDR_FIELD_MASK = 8'h00_77;
    // Control byte fields.
    localparam int PCB_TYPE_HI = 7;
    localparam int PCB_SEQ = 6;
    localparam int PCB_MORE = 5;
    localparam int PCB_RSEQ = 4;
    localparam int PCB_SRESP = 5;
    localparam logic [7:0] PCB_I = 8'h00_00;
    localparam logic [7:0] PCB_R = 8'h00_80;
    localparam logic [7:0] PCB_S = 8'h00_C0;
    localparam logic [7:0] PCB_I_MASK = 8'h00_80;
    localparam logic [7:0] PCB_R_MASK = 8'h00_E0;
    localparam logic [7:0] PCB_S_MASK = 8'h00_C0;
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_CHECK = 4'h1;
    localparam logic [3:0] ERR_OTHER = 4'h2;
    localparam logic [4:0] S_RESTART = 5'h00;
    localparam logic [4:0] S_SIZE = 5'h01;
    localparam logic [4:0] S_ABORT = 5'h02;
    localparam logic [4:0] S_WAIT = 5'h03;
    localparam logic [4:0] S_VPP = 5'h04;
    // Wishbone register map (byte addresses).
    localparam logic [7:0] REG_CTRL = 8'h00_00;
    localparam logic [7:0] REG_STATUS = 8'h00_04;
    localparam logic [7:0] REG_RXHDR = 8'h00_08;
    localparam logic [7:0] REG_LIMIT = 8'h00_0C;
    localparam int CTRL_SEND_WAIT = 0;
    localparam int CTRL_SEND_ABORT = 1;
    localparam int CTRL_RESTART = 2;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_HDR = 6'b000010,
        ST_PAY = 6'b000100,
        ST_CHK = 6'b001000,
        ST_DECIDE = 6'b010000,
        ST_SEND = 6'b100000
    } hbf_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] protocol_control_byte;
        logic [7:0] len;
    } hbf_hdr_type;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
    } hbf_byte_type;
endpackage

// file: core/hbf_check.sv
// Running exclusive-OR check accumulator for one block.
`timescale 1ns/1ps
module hbf_check (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Byte stream
    input wire logic i_clear,
    input wire logic i_en,
    input wire logic [7:0] i_data,
    output logic [7:0] o_sum
);
    typedef struct packed {
        logic [7:0] sum;
    } hbf_chk_st_type;
    hbf_chk_st_type s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (i_clear) begin
            s_nxt.sum = '0;
        end else if (i_en) begin
            s_nxt.sum = s_r.sum ^ i_data; // RULE22
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_sum = s_r.sum;
endmodule

// file: core/hbf_mem.sv
// Payload memory with registered read data.
`timescale 1ns/1ps
module hbf_mem (
    // Clock
    input wire logic i_clk,
    // Write port
    input wire logic i_we,
    input wire logic [7:0] i_waddr,
    input wire logic [7:0] i_wdata,
    // Read port
    input wire logic [7:0] i_raddr,
    output logic [7:0] o_rdata
);
    logic [7:0] mem [0:255];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule

// file: core/hbf_top.sv
// Card-side half-duplex block framer: receives a block, answers with a block.
//
// Overview of operation
// RULE1 - Block is address, control, count, payload, check.
// RULE2 - Address bits b8 and b4 sent zero.
// RULE3 - Only node addresses zero are supported.
// RULE4 - First terminal block fixes the connection pair.
// RULE5 - Information block: b8 zero, b7 sequence, b6 more.
// RULE6 - Acknowledge block: 100, b5 expected, b4..b1 error.
// RULE7 - Error codes: 0 none, 1 check, 2 other.
// RULE8 - Supervisory block: b8 b7 set, b6 response.
// RULE9 - Supervisory codes: restart, size, abort, wait, voltage; code rejects voltage (code 4) with error code 2.
// RULE10 - Count equals payload bytes; FF never sent.
// RULE11 - Payload presence fixed by block type.
// RULE12 - Sender appends check byte; receiver verifies it.
// RULE13 - Each supervisory request gets matching response; code answers a voltage request with an acknowledge block, error code 2.
// RULE14 - Terminal starts with sequence-0 information or supervisory.
// RULE15 - Unchained information block answered by information block.
// RULE16 - Chained block answered by acknowledge, next sequence.
// RULE17 - Card requests wait extension when it needs it.
// RULE18 - Size request echoed; new limit kept till next.
// RULE19 - After count and check, receiver takes turn.
// RULE20 - Receive size limit defaults to 32 bytes.
// RULE21 - Oversize count rejected with error code 2.
// RULE22 - Check byte is XOR of all block bytes.
// RULE23 - Send sequence starts at zero, toggles per block.
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module hbf_top (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // Received byte stream from the character layer
    input wire logic I_RX_VALID,
    input wire logic [7:0] I_RX_DATA,
    // Transmitted byte stream to the character layer
    output logic O_TX_VALID,
    output logic [7:0] O_TX_DATA,
    output logic O_TX_LAST,
    input wire logic I_TX_READY,
    // Classic Wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK
);
    typedef struct packed {
        hbf_pkg::hbf_state_type st;
        hbf_pkg::hbf_hdr_type rx;
        hbf_pkg::hbf_hdr_type tx;
        logic [7:0] cnt;
        logic [7:0] limit;
        logic [7:0] resp_pay;
        logic resp_has_pay;
        logic [7:0] tx_idx;
        logic send_seq;
        logic conn_open;
        logic [5:0] conn_pair;
        logic req_wait;
        logic req_abort;
        logic [7:0] wait_mult;
        logic pend_s_req;
        logic [4:0] pend_s_code;
        logic [3:0] last_err;
        logic [7:0] blocks;
        logic tx_valid;
        logic [7:0] tx_data;
        logic tx_last;
        logic [31:0] wb_dat;
        logic wb_ack;
    } hbf_st_type;

    hbf_st_type s_r, s_nxt;
    logic [7:0] chk_sum;
    logic [7:0] mem_rdata;
    logic chk_clear, chk_en;
    logic [7:0] chk_data;
    logic mem_we;
    logic [7:0] rx_d1_r, rx_d2_r;
    logic rx_v1_r, rx_v2_r;

    // Decodes the block type of a control byte.
    function automatic logic is_type(input logic [7:0] protocol_control_byte, input logic [7:0] mask, input logic [7:0] code);
        is_type = (protocol_control_byte & mask) == code;
    endfunction

    // The byte stream comes from another domain in general, so it is synchronised.
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            rx_d1_r <= '0;
            rx_d2_r <= '0;
            rx_v1_r <= 1'b0;
            rx_v2_r <= 1'b0;
        end else begin
            rx_d1_r <= I_RX_DATA;
            rx_d2_r <= rx_d1_r;
            rx_v1_r <= I_RX_VALID;
            rx_v2_r <= rx_v1_r;
        end
    end

    logic rx_take;
    logic rx_v3_r;
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            rx_v3_r <= 1'b0;
        end else begin
            rx_v3_r <= rx_v2_r;
        end
    end
    assign rx_take = rx_v2_r & ~rx_v3_r;

    hbf_check u_check (
        .i_clk(I_CLK),
        .i_reset(I_RESET),
        .i_clear(chk_clear),
        .i_en(chk_en),
        .i_data(chk_data),
        .o_sum(chk_sum)
    );

    hbf_mem u_mem (
        .i_clk(I_CLK),
        .i_we(mem_we),
        .i_waddr(s_r.cnt),
        .i_wdata(rx_d2_r),
        .i_raddr(s_r.tx_idx),
        .o_rdata(mem_rdata)
    );

    logic wb_hit;
    assign wb_hit = I_WB_CYC & I_WB_STB & ~s_r.wb_ack;

    always_comb begin
        logic [3:0] err;
        logic [4:0] scode;
        logic exp_seq;
        err = hbf_pkg::ERR_NONE;
        scode = '0;
        exp_seq = 1'b0;
        s_nxt = s_r;
        chk_clear = 1'b0;
        chk_en = 1'b0;
        chk_data = rx_d2_r;
        mem_we = 1'b0;
        s_nxt.wb_ack = wb_hit;
        // Register bus.
        if (wb_hit) begin
            s_nxt.wb_dat = '0;
            unique case (I_WB_ADR)
                hbf_pkg::REG_CTRL: begin
                    if (I_WB_WE && I_WB_SEL[0]) begin
                        s_nxt.req_wait = s_r.req_wait | I_WB_DAT[hbf_pkg::CTRL_SEND_WAIT];
                        s_nxt.req_abort = s_r.req_abort | I_WB_DAT[hbf_pkg::CTRL_SEND_ABORT];
                        if (I_WB_DAT[hbf_pkg::CTRL_RESTART]) begin
                            s_nxt.send_seq = 1'b0;
                        end
                    end
                    if (I_WB_WE && I_WB_SEL[1]) begin
                        s_nxt.wait_mult = I_WB_DAT[15:8];
                    end
                    s_nxt.wb_dat = {16'h0000, s_r.wait_mult, 5'h00, s_r.pend_s_req, s_r.req_abort, s_r.req_wait};
                end
                hbf_pkg::REG_STATUS: begin
                    s_nxt.wb_dat = {s_r.blocks, 4'h0, s_r.last_err, 7'h00, s_r.conn_open, 2'b00, s_r.st};
                end
                hbf_pkg::REG_RXHDR: begin
                    s_nxt.wb_dat = {8'h00, s_r.rx};
                end
                hbf_pkg::REG_LIMIT: begin
                    s_nxt.wb_dat = {24'h00_0000, s_r.limit};
                end
                default: begin
                    s_nxt.wb_dat = '0;
                end
            endcase
        end
        unique case (s_r.st)
            hbf_pkg::ST_IDLE: begin
                chk_clear = 1'b1;
                s_nxt.cnt = '0;
                if (rx_take) begin
                    chk_clear = 1'b0;
                    chk_en = 1'b1; // RULE12
                    s_nxt.rx.addr = rx_d2_r;
                    s_nxt.cnt = 8'h01;
                    s_nxt.st = hbf_pkg::ST_HDR; // RULE1
                end
            end
            hbf_pkg::ST_HDR: begin
                if (rx_take) begin
                    chk_en = 1'b1;
                    s_nxt.cnt = s_r.cnt + 8'h01;
                    if (s_r.cnt == 8'h01) begin
                        s_nxt.rx.protocol_control_byte = rx_d2_r;
                    end else begin
                        s_nxt.rx.len = rx_d2_r;
                        s_nxt.cnt = '0;
                        s_nxt.st = (rx_d2_r == 8'h00) ? hbf_pkg::ST_CHK : hbf_pkg::ST_PAY; // RULE10
                    end
                end
            end
            hbf_pkg::ST_PAY: begin
                if (rx_take) begin
                    chk_en = 1'b1;
                    mem_we = 1'b1;
                    s_nxt.cnt = s_r.cnt + 8'h01;
                    if (s_nxt.cnt == s_r.rx.len) begin
                        s_nxt.st = hbf_pkg::ST_CHK;
                    end
                end
            end
            hbf_pkg::ST_CHK: begin
                if (rx_take) begin
                    chk_en = 1'b1;
                    s_nxt.st = hbf_pkg::ST_DECIDE; // RULE19
                end
            end
            hbf_pkg::ST_DECIDE: begin
                // Validation order: check byte first, then framing, then content.
                exp_seq = ~s_r.rx.protocol_control_byte[hbf_pkg::PCB_SEQ];
                scode = s_r.rx.protocol_control_byte[4:0];
                s_nxt.resp_has_pay = 1'b0;
                s_nxt.pend_s_req = 1'b0;
                if (chk_sum != 8'h00) begin
                    err = hbf_pkg::ERR_CHECK; // RULE12
                end else if (s_r.rx.addr[hbf_pkg::ADDR_UNUSED_HI] || s_r.rx.addr[hbf_pkg::ADDR_UNUSED_LO]
                             || (s_r.rx.addr & hbf_pkg::ADDR_FIELD_MASK) != 8'h00) begin
                    err = hbf_pkg::ERR_OTHER; // RULE3
                end else if (s_r.conn_open && s_r.rx.addr[5:0] != s_r.conn_pair) begin
                    err = hbf_pkg::ERR_OTHER; // RULE4
                end else if (s_r.rx.len == hbf_pkg::LEN_RESERVED || s_r.rx.len > s_r.limit) begin
                    err = hbf_pkg::ERR_OTHER; // RULE21
                end else if (!s_r.conn_open && is_type(s_r.rx.protocol_control_byte, hbf_pkg::PCB_I_MASK, hbf_pkg::PCB_I)
                             && s_r.rx.protocol_control_byte[hbf_pkg::PCB_SEQ]) begin
                    err = hbf_pkg::ERR_OTHER; // RULE14
                end else if (is_type(s_r.rx.protocol_control_byte, hbf_pkg::PCB_R_MASK, hbf_pkg::PCB_R)
                             && s_r.rx.len != 8'h00) begin
                    err = hbf_pkg::ERR_OTHER; // RULE11
                end else if (is_type(s_r.rx.protocol_control_byte, hbf_pkg::PCB_S_MASK, hbf_pkg::PCB_S)) begin
                    if (scode > hbf_pkg::S_WAIT) begin
                        err = hbf_pkg::ERR_OTHER; // RULE9
                    end else if ((scode == hbf_pkg::S_SIZE || scode == hbf_pkg::S_WAIT)
                                 != (s_r.rx.len == 8'h01)) begin
                        err = hbf_pkg::ERR_OTHER; // RULE11
                    end
                end
                if (err == hbf_pkg::ERR_NONE) begin
                    s_nxt.conn_open = 1'b1;
                    s_nxt.conn_pair = s_r.rx.addr[5:0]; // RULE4
                end
                s_nxt.last_err = err;
                s_nxt.blocks = s_r.blocks + 8'h01;
                s_nxt.tx.addr = 8'h00; // RULE2
                s_nxt.tx.len = 8'h00;
                if (err != hbf_pkg::ERR_NONE) begin
                    s_nxt.tx.protocol_control_byte = hbf_pkg::PCB_R | {3'b000, s_r.rx.protocol_control_byte[hbf_pkg::PCB_SEQ], err}; // RULE6 RULE7
                end else if (is_type(s_r.rx.protocol_control_byte, hbf_pkg::PCB_S_MASK, hbf_pkg::PCB_S)) begin
                    if (!s_r.rx.protocol_control_byte[hbf_pkg::PCB_SRESP]) begin // RULE8
                        s_nxt.tx.protocol_control_byte = hbf_pkg::PCB_S | {3'b001, scode}; // RULE13
                        s_nxt.tx.len = s_r.rx.len;
                        s_nxt.resp_has_pay = s_r.rx.len != 8'h00;
                        if (scode == hbf_pkg::S_SIZE) begin
                            s_nxt.limit = mem_rdata; // RULE18
                        end
                        if (scode == hbf_pkg::S_RESTART) begin
                            s_nxt.send_seq = 1'b0;
                        end
                    end else begin
                        // A response closes our own request; give the turn back.
                        s_nxt.tx.protocol_control_byte = hbf_pkg::PCB_R | {3'b000, s_r.send_seq, hbf_pkg::ERR_NONE};
                    end
                end else if (is_type(s_r.rx.protocol_control_byte, hbf_pkg::PCB_I_MASK, hbf_pkg::PCB_I)
                             && s_r.rx.protocol_control_byte[hbf_pkg::PCB_MORE]) begin // RULE5
                    s_nxt.tx.protocol_control_byte = hbf_pkg::PCB_R | {3'b000, exp_seq, hbf_pkg::ERR_NONE}; // RULE16
                end else if (s_r.req_wait || s_r.req_abort) begin
                    scode = s_r.req_wait ? hbf_pkg::S_WAIT : hbf_pkg::S_ABORT;
                    s_nxt.tx.protocol_control_byte = hbf_pkg::PCB_S | {3'b000, scode}; // RULE17
                    s_nxt.tx.len = s_r.req_wait ? 8'h01 : 8'h00;
                    s_nxt.resp_pay = s_r.wait_mult;
                    s_nxt.pend_s_req = 1'b1;
                    s_nxt.pend_s_code = scode;
                    s_nxt.req_wait = 1'b0;
                    s_nxt.req_abort = 1'b0;
                end else begin
                    // Unchained or acknowledged: answer with an empty information block.
                    s_nxt.tx.protocol_control_byte = {1'b0, s_r.send_seq, 6'h00}; // RULE15 RULE23
                    s_nxt.send_seq = ~s_r.send_seq; // RULE23
                end
                if (wb_hit && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == hbf_pkg::REG_CTRL) begin
                    s_nxt.req_wait = s_nxt.req_wait | I_WB_DAT[hbf_pkg::CTRL_SEND_WAIT];
                    s_nxt.req_abort = s_nxt.req_abort | I_WB_DAT[hbf_pkg::CTRL_SEND_ABORT];
                end
                s_nxt.tx_idx = '0;
                s_nxt.cnt = '0;
                chk_clear = 1'b1;
                s_nxt.st = hbf_pkg::ST_SEND;
            end
            hbf_pkg::ST_SEND: begin
                if (!s_r.tx_valid || I_TX_READY) begin
                    s_nxt.tx_valid = 1'b1;
                    s_nxt.tx_last = 1'b0;
                    s_nxt.cnt = s_r.cnt + 8'h01;
                    chk_en = 1'b1;
                    if (s_r.cnt == 8'h00) begin
                        chk_data = s_r.tx.addr;
                    end else if (s_r.cnt == 8'h01) begin
                        chk_data = s_r.tx.protocol_control_byte;
                    end else if (s_r.cnt == 8'h02) begin
                        chk_data = s_r.tx.len;
                    end else if (s_r.cnt < s_r.tx.len + 8'h03) begin
                        chk_data = s_r.pend_s_req ? s_r.resp_pay : mem_rdata;
                    end else begin
                        chk_en = 1'b0;
                        chk_data = chk_sum; // RULE22
                        s_nxt.tx_last = 1'b1;
                    end
                    s_nxt.tx_data = chk_data;
                    if (s_r.cnt == 8'h01) begin
                        s_nxt.tx_idx = s_r.tx_idx;
                    end
                    if (s_r.tx_last) begin
                        s_nxt.tx_valid = 1'b0;
                        s_nxt.tx_last = 1'b0;
                        chk_en = 1'b0;
                        s_nxt.st = hbf_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                s_nxt.st = hbf_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            s_r <= '0;
            s_r.st <= hbf_pkg::ST_IDLE;
            s_r.limit <= hbf_pkg::DEFAULT_SIZE_LIMIT; // RULE20
        end else begin
            s_r <= s_nxt;
        end
    end

    assign O_TX_VALID = s_r.tx_valid;
    assign O_TX_DATA = s_r.tx_data;
    assign O_TX_LAST = s_r.tx_last;
    assign O_WB_DAT = s_r.wb_dat;
    assign O_WB_ACK = s_r.wb_ack;
endmodule

// file: dv/hbf_assertions.sv
// Checker for the framer transmit stream and bus answer.
`timescale 1ns/1ps
module hbf_assertions (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET,
    // Transmit stream
    input wire logic O_TX_VALID,
    input wire logic [7:0] O_TX_DATA,
    input wire logic O_TX_LAST,
    input wire logic I_TX_READY,
    // Bus
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic O_WB_ACK
);
    // Byte position, running check and header of the block being sent.
    logic [7:0] idx_r;
    logic [7:0] sum_r;
    logic [7:0] pcb_r;
    logic [7:0] len_r;
    logic acc;
    assign acc = O_TX_VALID && I_TX_READY;
    always_ff @(posedge I_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            idx_r <= 8'h00;
            sum_r <= 8'h00;
            pcb_r <= 8'h00;
            len_r <= 8'h00;
        end else if (acc) begin
            idx_r <= O_TX_LAST ? 8'h00 : idx_r + 8'h01;
            sum_r <= O_TX_LAST ? 8'h00 : sum_r ^ O_TX_DATA;
            if (idx_r == 8'h01) pcb_r <= O_TX_DATA;
            if (idx_r == 8'h02) len_r <= O_TX_DATA;
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    property p_addr_unused;
        acc && idx_r == 8'h00 |-> (O_TX_DATA & 8'h88) == 8'h00;
    endproperty
    a_addr_unused: assert property (p_addr_unused) else $error("unused address bits set");
    property p_addr_zero;
        acc && idx_r == 8'h00 |-> (O_TX_DATA & 8'h77) == 8'h00;
    endproperty
    a_addr_zero: assert property (p_addr_zero) else $error("node address not zero");
    property p_lrc;
        acc && O_TX_LAST |-> (sum_r ^ O_TX_DATA) == 8'h00;
    endproperty
    a_lrc: assert property (p_lrc) else $error("check byte wrong");
    property p_last;
        acc && idx_r >= 8'h03 |-> O_TX_LAST == (idx_r == len_r + 8'h03);
    endproperty
    a_last: assert property (p_last) else $error("block length wrong");
    property p_rlen;
        acc && idx_r == 8'h02 && pcb_r[7:5] == 3'b100 |-> O_TX_DATA == 8'h00;
    endproperty
    a_rlen: assert property (p_rlen) else $error("ack block with payload");
    property p_slen;
        acc && idx_r == 8'h02 && pcb_r[7:6] == 2'b11 && pcb_r[0] |-> O_TX_DATA == 8'h01;
    endproperty
    a_slen: assert property (p_slen) else $error("supervisory payload count wrong");
    property p_rcode;
        acc && idx_r == 8'h01 && O_TX_DATA[7:5] == 3'b100 |-> O_TX_DATA[3:0] <= 4'h2;
    endproperty
    a_rcode: assert property (p_rcode) else $error("reserved error code");
    property p_scode;
        acc && idx_r == 8'h01 && O_TX_DATA[7:6] == 2'b11 |-> O_TX_DATA[4:0] <= 5'h03;
    endproperty
    a_scode: assert property (p_scode) else $error("bad supervisory code");
    property p_hold;
        O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_DATA) && $stable(O_TX_LAST);
    endproperty
    a_hold: assert property (p_hold) else $error("transmit byte dropped");
    property p_ack;
        I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK ##1 !O_WB_ACK;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer not one pulse");
endmodule
bind hbf_top hbf_assertions hbf_assertions_i (.I_CLK(I_CLK), .I_RESET(I_RESET), .O_TX_VALID(O_TX_VALID),
    .O_TX_DATA(O_TX_DATA), .O_TX_LAST(O_TX_LAST), .I_TX_READY(I_TX_READY), .I_WB_CYC(I_WB_CYC),
    .I_WB_STB(I_WB_STB), .O_WB_ACK(O_WB_ACK));

// file: dv/hbf_term_model.sv
// Terminal model: sends blocks byte by byte and collects the replies.
`timescale 1ns/1ps
module hbf_term_model (
    // Clock
    input wire logic i_clk,
    // Bytes to the framer
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    // Bytes from the framer
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_last,
    output logic o_tx_ready
);
    logic slow = 1'b0;
    int blocks = 0;
    logic [7:0] rq[$];
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data = 8'h00;
        o_tx_ready = 1'b0;
    end
    // A released data line shows the inverse so a stale byte is never read as good.
    task automatic put(input logic [7:0] b);
        o_rx_data <= b;
        repeat (2) @(posedge i_clk);
        o_rx_valid <= 1'b1;
        repeat (2) @(posedge i_clk);
        o_rx_valid <= 1'b0;
        o_rx_data <= ~b;
        repeat (2) @(posedge i_clk);
    endtask
    task automatic send(input logic [7:0] addr, protocol_control_byte, len, pay, input logic bad);
        logic [7:0] x;
        x = addr ^ protocol_control_byte ^ len;
        put(addr);
        put(protocol_control_byte);
        put(len);
        for (int k = 0; k < len; k++) begin
            put(pay);
            x ^= pay;
        end
        put(bad ? ~x : x);
    endtask
    always @(posedge i_clk) begin
        o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
        if (i_tx_valid && o_tx_ready) begin
            rq.push_back(i_tx_data);
            if (i_tx_last) blocks++;
        end
    end
endmodule

// file: dv/testbench.sv
// Self-checking bench for the card-side block framer.
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic rxv, txv, txl, txr, ack;
    logic [7:0] rxd, txd;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat, rd;
    int bad_count = 0;
    int samples_checked = 0;
    // Row: address, control, count, fill byte, corrupt flag, reply control, reply count.
    logic [55:0] rows [11] = '{56'h00_0000_0000_0000, 56'h00_4000_0000_4000, 56'h00_C000_0000_E000,
        56'h00_2000_0000_9000, 56'h00_4000_0000_0000, 56'h00_0000_0001_8100, 56'h11_0000_0000_8200,
        56'h00_C200_0000_E200, 56'h00_C101_1000_E101, 56'h00_0010_5A00_4000, 56'h00_4011_A500_9200};
    hbf_top hbf_top_i (.I_CLK(clk), .I_RESET(rst), .I_RX_VALID(rxv), .I_RX_DATA(rxd), .O_TX_VALID(txv),
        .O_TX_DATA(txd), .O_TX_LAST(txl), .I_TX_READY(txr), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack));
    hbf_term_model hbf_term_model_i (.i_clk(clk), .o_rx_valid(rxv), .o_rx_data(rxd), .i_tx_valid(txv),
        .i_tx_data(txd), .i_tx_last(txl), .o_tx_ready(txr));
    initial begin
        forever #2.5 clk = ~clk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
        if (n == 20) begin
            bad_count++;
            finish_test();
        end
    endtask
    // Half duplex: the next block goes out only after the whole reply came back.
    task automatic reply(input logic [7:0] protocol_control_byte, len, pay);
        int n = 0;
        logic [7:0] x = 8'h00;
        while (hbf_term_model_i.blocks == 0 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        if (n == 3000) begin
            bad_count++;
            finish_test();
        end
        check("size", 32'(hbf_term_model_i.rq.size()), len + 4);
        check("addr", hbf_term_model_i.rq[0], 8'h00);
        check("ctrl", hbf_term_model_i.rq[1], protocol_control_byte);
        check("count", hbf_term_model_i.rq[2], len);
        if (len == 8'h01) check("data", hbf_term_model_i.rq[3], pay);
        foreach (hbf_term_model_i.rq[k]) x ^= hbf_term_model_i.rq[k];
        check("lrc", x, 8'h00);
        hbf_term_model_i.rq.delete();
        hbf_term_model_i.blocks = 0;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        wb(1'b0, hbf_pkg::REG_LIMIT, 32'h0000_0000, rd);
        check("limit", rd, 32'h0000_0020);
        wb(1'b0, 8'h40, 32'h0000_0000, rd);
        check("unmapped", rd, 32'h0000_0000);
        foreach (rows[r]) begin
            hbf_term_model_i.slow = (r % 2 == 1);
            hbf_term_model_i.send(rows[r][55:48], rows[r][47:40], rows[r][39:32], rows[r][31:24], rows[r][16]);
            reply(rows[r][15:8], rows[r][7:0], rows[r][31:24]);
        end
        wb(1'b1, hbf_pkg::REG_CTRL, 32'h0000_0501, rd);
        hbf_term_model_i.send(8'h00, 8'h40, 8'h00, 8'h00, 1'b0);
        reply(8'hC3, 8'h01, 8'h05);
        wb(1'b0, hbf_pkg::REG_CTRL, 32'h0000_0000, rd);
        check("wait pending", rd[0], 1'b0);
        hbf_term_model_i.send(8'h00, 8'hE3, 8'h01, 8'h05, 1'b0);
        reply(8'h80, 8'h00, 8'h00);
        wb(1'b0, hbf_pkg::REG_LIMIT, 32'h0000_0000, rd);
        check("limit", rd, 32'h0000_0010);
        wb(1'b0, hbf_pkg::REG_RXHDR, 32'h0000_0000, rd);
        check("header", rd, 32'h0000_E301);
        wb(1'b0, hbf_pkg::REG_STATUS, 32'h0000_0000, rd);
        check("open", rd[8], 1'b1);
        wb(1'b1, hbf_pkg::REG_CTRL, 32'h0000_0002, rd);
        hbf_term_model_i.send(8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
        reply(8'hC2, 8'h00, 8'h00);
        // A reset in mid-run must bring back the default limit and sequence zero.
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        wb(1'b0, hbf_pkg::REG_LIMIT, 32'h0000_0000, rd);
        check("limit after reset", rd, 32'h0000_0020);
        hbf_term_model_i.send(8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
        reply(8'h00, 8'h00, 8'h00);
        finish_test();
    end
endmodule
